/* File: verilog/dps_map.svh */
// Purpose: constants for the dual supply reset and wiper select block
// Assumes: included by its bare name from design files
// Notes:   values only, no logic
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// --------------------------------------------------------------------
// wiper resolution and defaults
// --------------------------------------------------------------------
`define DPS_WIPER_BITS   8
`define DPS_MID_8BIT     8'h7F
`define DPS_MID_7BIT     8'h3F
`define DPS_TERMINAL_CONNECT_REGISTER_BITS    4
`define DPS_TERMINAL_CONNECT_REGISTER_RESET   4'hF

// --------------------------------------------------------------------
// synchroniser depth and full-scale and zero codes
// --------------------------------------------------------------------
`define DPS_SYNC_STAGES  2
`define DPS_FULL_8BIT    8'hFF
`define DPS_FULL_7BIT    8'h7F
`define DPS_ZERO_CODE    8'h00

`endif

/* File: verilog/dps_pkg.sv */
// Purpose: shared types for the dual supply reset and wiper select block
// Assumes: used through scoped names, never imported
// Notes:   state codes are one-hot
package dps_pkg;

    // ----------------------------------------------------------------
    // supply state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        DPS_ST_DOWN     = 4'h1,
        DPS_ST_ANALOG   = 4'h2,
        DPS_ST_DIGITAL  = 4'h4,
        DPS_ST_BOTH     = 4'h8
    } dps_state_e;

    // ----------------------------------------------------------------
    // volatile memory commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DPS_OP_WRITE_WIPER = 3'h0,
        DPS_OP_READ_WIPER  = 3'h1,
        DPS_OP_INCREMENT   = 3'h2,
        DPS_OP_DECREMENT   = 3'h3,
        DPS_OP_WRITE_TERMINAL_CONNECT_REGISTER  = 3'h4,
        DPS_OP_READ_TERMINAL_CONNECT_REGISTER   = 3'h5
    } dps_op_e;

    typedef struct packed {
        dps_op_e    op;
        logic [7:0] data;
    } dps_cmd_s;

endpackage

/* File: verilog/dps_reset_sync.sv */
// Purpose: reset synchroniser, asynchronous assert, synchronous release
// Assumes: powerGood low means the supply is below its trip point
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
`include "dps_map.svh"

module dps_reset_sync #(
    parameter int STAGES = `DPS_SYNC_STAGES
) (
    input  wire logic clk_sys,
    input  wire logic powerGood,
    output logic      ready
);

    logic [STAGES-1:0] stage_q;

    // ----------------------------------------------------------------
    // shift chain cleared at once by a failing supply
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge powerGood) begin
        if (!powerGood) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[STAGES-2:0], 1'b1};
        end
    end

    assign ready = stage_q[STAGES-1];

endmodule

/* File: verilog/dps_por_wiper_select.sv */
// Purpose: power-on and brown-out wiper source selection for two supplies
// Assumes: power-good levels are asynchronous, commands synchronous
// Notes:   wiper code is zero-extended to 8 bits for the 7-bit variant
//
// Behaviour
// - digital power-on loads the wiper register with the default code
// - digital power-on loads the terminal-connect register defaults
// - default code is 7Fh for 8-bit, 3Fh for 7-bit, analog-independent
// - commands are accepted only after digital reset has released
// - analog valid while digital in reset gives a mid-scale wiper
// - analog valid after digital release gives the register value
// - digital out of reset means the wiper register sets the wiper
// - digital brown-out with analog valid reverts wiper to mid-scale
// - low-supply region still runs increment, decrement, read, write
// - during digital brown-out all commands are ignored
`timescale 1ns/1ns
`include "dps_map.svh"

module dps_por_wiper_select #(
    parameter int WIPER_BITS = `DPS_WIPER_BITS
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 digitalPowerGood,
    input  wire logic                 analogPowerGood,
    input  wire logic                 cmdValid,
    input  wire dps_pkg::dps_cmd_s    cmd,
    output logic                      cmdDone_q,
    output logic [7:0]                readData_q,
    output logic [7:0]                wiperCode_q,
    output logic                      wiperValid_q,
    output logic [`DPS_TERMINAL_CONNECT_REGISTER_BITS-1:0] tconOut_q,
    output logic [3:0]                supplyState_q
);

    // ----------------------------------------------------------------
    // variant constants
    // ----------------------------------------------------------------
    localparam logic [7:0] MidCode  = (WIPER_BITS == 8) ?
                                      `DPS_MID_8BIT : `DPS_MID_7BIT;
    localparam logic [7:0] FullCode = (WIPER_BITS == 8) ?
                                      `DPS_FULL_8BIT : `DPS_FULL_7BIT;

    logic                        digReady;
    logic                        anaReady;
    logic [7:0]                  wiperReg_q;
    logic [7:0]                  wiperReg_d;
    logic [`DPS_TERMINAL_CONNECT_REGISTER_BITS-1:0]   terminal_connect_register_q;
    logic [`DPS_TERMINAL_CONNECT_REGISTER_BITS-1:0]   terminal_connect_register_d;
    dps_pkg::dps_state_e         state_q;
    dps_pkg::dps_state_e         state_d;
    logic                        cmdTake;
    logic                        opWrite;
    logic                        opIncr;
    logic                        opDecr;
    logic                        opTconWr;
    logic                        opTconRd;
    logic [7:0]                  writeCode;
    logic [7:0]                  incrCode;
    logic [7:0]                  decrCode;
    logic [7:0]                  readSel;
    logic [7:0]                  wiperCode_d;
    logic                        analogUp;

    // ----------------------------------------------------------------
    // supply reset synchronisers
    // ----------------------------------------------------------------
    // assert at once, release after two edges
    dps_reset_sync #(
        .STAGES    (`DPS_SYNC_STAGES)
    ) u_digSync (
        .clk_sys   (clk_sys),
        .powerGood (digitalPowerGood),
        .ready     (digReady)
    );

    dps_reset_sync #(
        .STAGES    (`DPS_SYNC_STAGES)
    ) u_anaSync (
        .clk_sys   (clk_sys),
        .powerGood (analogPowerGood),
        .ready     (anaReady)
    );

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // gated by the digital reset, so brown-out drops everything
    assign cmdTake  = cmdValid && digReady && !reset;
    assign opWrite  = cmd.op == dps_pkg::DPS_OP_WRITE_WIPER;
    assign opIncr   = cmd.op == dps_pkg::DPS_OP_INCREMENT;
    assign opDecr   = cmd.op == dps_pkg::DPS_OP_DECREMENT;
    assign opTconWr = cmd.op == dps_pkg::DPS_OP_WRITE_TERMINAL_CONNECT_REGISTER;
    assign opTconRd = cmd.op == dps_pkg::DPS_OP_READ_TERMINAL_CONNECT_REGISTER;

    // saturating arithmetic and clipped write data
    assign writeCode = (cmd.data > FullCode) ? FullCode : cmd.data;
    assign incrCode  = (wiperReg_q == FullCode) ? wiperReg_q :
                       8'(wiperReg_q + 8'h01);
    assign decrCode  = (wiperReg_q == `DPS_ZERO_CODE) ? wiperReg_q :
                       8'(wiperReg_q - 8'h01);
    assign readSel   = opTconRd ?
                       {{(8-`DPS_TERMINAL_CONNECT_REGISTER_BITS){1'b0}}, terminal_connect_register_q} : wiperReg_q;

    // volatile memory next values
    assign wiperReg_d = !cmdTake ? wiperReg_q :
                        opWrite  ? writeCode  :
                        opIncr   ? incrCode   :
                        opDecr   ? decrCode   : wiperReg_q;
    assign terminal_connect_register_d     = (cmdTake && opTconWr) ?
                        cmd.data[`DPS_TERMINAL_CONNECT_REGISTER_BITS-1:0] : terminal_connect_register_q;

    // ----------------------------------------------------------------
    // volatile registers, default while the digital supply is low
    // ----------------------------------------------------------------
    // mid-scale and terminal defaults at power-on
    always_ff @(posedge clk_sys or negedge digReady) begin
        if (!digReady) begin
            wiperReg_q <= MidCode;
            terminal_connect_register_q     <= `DPS_TERMINAL_CONNECT_REGISTER_RESET;
        end else if (reset) begin
            wiperReg_q <= MidCode;
            terminal_connect_register_q     <= `DPS_TERMINAL_CONNECT_REGISTER_RESET;
        end else begin
            wiperReg_q <= wiperReg_d;
            terminal_connect_register_q     <= terminal_connect_register_d;
        end
    end

    // ----------------------------------------------------------------
    // command answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmdDone_q  <= 1'b0;
            readData_q <= `DPS_ZERO_CODE;
        end else begin
            cmdDone_q  <= cmdTake;
            readData_q <= cmdTake ? readSel : readData_q;
        end
    end

    // ----------------------------------------------------------------
    // supply state from the synchronised resets
    // ----------------------------------------------------------------
    assign state_d = (digReady && anaReady) ? dps_pkg::DPS_ST_BOTH    :
                     anaReady               ? dps_pkg::DPS_ST_ANALOG  :
                     digReady               ? dps_pkg::DPS_ST_DIGITAL :
                                              dps_pkg::DPS_ST_DOWN;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= dps_pkg::DPS_ST_DOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // wiper source: register when digital up, else mid-scale
    // ----------------------------------------------------------------
    always_comb begin
        wiperCode_d = MidCode;
        unique case (state_q)
            dps_pkg::DPS_ST_BOTH:    wiperCode_d = wiperReg_q;
            dps_pkg::DPS_ST_DIGITAL: wiperCode_d = wiperReg_q;
            dps_pkg::DPS_ST_ANALOG:  wiperCode_d = MidCode;
            dps_pkg::DPS_ST_DOWN:    wiperCode_d = MidCode;
            default:                 wiperCode_d = MidCode;
        endcase
    end

    // analog side synchronised valid, with or without digital
    assign analogUp = (state_q == dps_pkg::DPS_ST_ANALOG) ||
                      (state_q == dps_pkg::DPS_ST_BOTH);

    // brown-out falls back to mid-scale via the state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wiperCode_q   <= MidCode;
            wiperValid_q  <= 1'b0;
            tconOut_q     <= `DPS_TERMINAL_CONNECT_REGISTER_RESET;
            supplyState_q <= dps_pkg::DPS_ST_DOWN;
        end else begin
            wiperCode_q   <= wiperCode_d;
            wiperValid_q  <= analogUp;
            tconOut_q     <= terminal_connect_register_q;
            supplyState_q <= state_q;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_wiper_por_load: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(digReady) |-> wiperReg_q == MidCode)
        else $error("wiper register not default after power-on");

    chk_terminal_connect_register_por_load: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(digReady) |-> terminal_connect_register_q == `DPS_TERMINAL_CONNECT_REGISTER_RESET)
        else $error("terminal register not default after power-on");

    chk_mid_code_value: assert property (
        @(posedge clk_sys) disable iff (reset)
        !digReady |-> wiperReg_q == ((WIPER_BITS == 8) ?
                                     `DPS_MID_8BIT : `DPS_MID_7BIT))
        else $error("default wiper code wrong for variant");

    chk_cmd_gated_reset: assert property (
        @(posedge clk_sys) disable iff (reset)
        !digReady ##1 !digReady |-> !cmdDone_q && $stable(wiperReg_q))
        else $error("command taken while digital supply in reset");

    chk_analog_only_mid: assert property (
        @(posedge clk_sys) disable iff (reset)
        state_q == dps_pkg::DPS_ST_ANALOG |=> wiperCode_q == MidCode
            && wiperValid_q)
        else $error("analog-only wiper not at mid-scale");

    chk_register_drives: assert property (
        @(posedge clk_sys) disable iff (reset)
        state_q == dps_pkg::DPS_ST_BOTH |=>
            wiperCode_q == $past(wiperReg_q) && wiperValid_q)
        else $error("wiper does not follow register");

    chk_brownout_mid: assert property (
        @(posedge clk_sys) disable iff (reset)
        $fell(digReady) && anaReady |-> ##2 wiperCode_q == MidCode)
        else $error("wiper not mid-scale after digital brown-out");

    chk_write_executes: assert property (
        @(posedge clk_sys) disable iff (reset)
        cmdTake && opWrite && digReady ##1 digReady
            |-> wiperReg_q == $past(writeCode) && cmdDone_q)
        else $error("accepted write not stored");

    chk_async_assert: assert property (
        @(posedge clk_sys) disable iff (reset)
        !digitalPowerGood |-> !digReady ##1 !digReady[*2])
        else $error("digital reset not held while supply low");

endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the dual supply wiper select block
// Assumes: 20 MHz clock, synchronous active-high reset, 8 and 7-bit variants
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`include "dps_map.svh"

module tb;

    // ----------------------------------------------------------------
    // signals and instance
    // ----------------------------------------------------------------
    logic              clk_sys;
    logic              reset;
    logic              digitalPowerGood;
    logic              analogPowerGood;
    logic              cmdValid;
    dps_pkg::dps_cmd_s cmd;
    logic              cmdDone_q;
    logic [7:0]        readData_q;
    logic [7:0]        wiperCode_q;
    logic              wiperValid_q;
    logic [3:0]        tconOut_q;
    logic [3:0]        supplyState_q;
    logic [7:0]        readData7;
    logic [7:0]        wiperCode7;
    int                err_total;
    int                samples_checked;
    int                cycles = 0;

    dps_por_wiper_select #(.WIPER_BITS(8)) uut (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .digitalPowerGood (digitalPowerGood),
        .analogPowerGood  (analogPowerGood),
        .cmdValid         (cmdValid),
        .cmd              (cmd),
        .cmdDone_q        (cmdDone_q),
        .readData_q       (readData_q),
        .wiperCode_q      (wiperCode_q),
        .wiperValid_q     (wiperValid_q),
        .tconOut_q        (tconOut_q),
        .supplyState_q    (supplyState_q)
    );

    // narrow variant on the same stimulus: clipping and its mid-scale
    dps_por_wiper_select #(.WIPER_BITS(7)) uut7 (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .digitalPowerGood (digitalPowerGood),
        .analogPowerGood  (analogPowerGood),
        .cmdValid         (cmdValid),
        .cmd              (cmd),
        .cmdDone_q        (),
        .readData_q       (readData7),
        .wiperCode_q      (wiperCode7),
        .wiperValid_q     (),
        .tconOut_q        (),
        .supplyState_q    ()
    );

    // clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one command, judged 1 ns after the edge that takes it, then an idle edge
    task automatic docmd(input dps_pkg::dps_op_e op, input logic [7:0] d,
                         input logic expDone);
        cmd.op   = op;
        cmd.data = d;
        cmdValid = 1'b1;
        step(1);
        cmdValid = 1'b0;
        chk("cmdDone", {7'h00, expDone}, {7'h00, cmdDone_q});
        step(1);
        chk("cmdDoneEnd", 8'h00, {7'h00, cmdDone_q});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        chk("wiper7", `DPS_MID_7BIT, wiperCode7);
        chk("terminal_connect_register", {4'h0, `DPS_TERMINAL_CONNECT_REGISTER_RESET}, {4'h0, tconOut_q});
        chk("valid", 8'h00, {7'h00, wiperValid_q});
        chk("state", 8'h01, {4'h0, supplyState_q});
        $display("test reset done");
    endtask

    task automatic t_analog_first();
        analogPowerGood = 1'b1;
        step(5);
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        chk("valid", 8'h01, {7'h00, wiperValid_q});
        chk("state", 8'h02, {4'h0, supplyState_q});
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h10, 1'b0);
        step(3);
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        $display("test analog first done");
    endtask

    task automatic t_digital_up();
        digitalPowerGood = 1'b1;
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h20, 1'b0);
        step(4);
        chk("state", 8'h08, {4'h0, supplyState_q});
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        $display("test digital up done");
    endtask

    task automatic t_commands();
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h40, 1'b1);
        step(2);
        chk("wiper", 8'h40, wiperCode_q);
        docmd(dps_pkg::DPS_OP_INCREMENT, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", 8'h41, readData_q);
        docmd(dps_pkg::DPS_OP_DECREMENT, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_DECREMENT, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", 8'h3F, readData_q);
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'hFF, 1'b1);
        docmd(dps_pkg::DPS_OP_INCREMENT, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", 8'hFF, readData_q);
        chk("read7", 8'h7F, readData7);
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_DECREMENT, 8'h00, 1'b1);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", 8'h00, readData_q);
        docmd(dps_pkg::DPS_OP_WRITE_TERMINAL_CONNECT_REGISTER, 8'h05, 1'b1);
        docmd(dps_pkg::DPS_OP_READ_TERMINAL_CONNECT_REGISTER, 8'h00, 1'b1);
        chk("readTcon", 8'h05, readData_q);
        chk("terminal_connect_register", 8'h05, {4'h0, tconOut_q});
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h55, 1'b1);
        step(2);
        chk("wiper", 8'h55, wiperCode_q);
        $display("test commands done");
    endtask

    task automatic t_brownout();
        digitalPowerGood = 1'b0;
        step(4);
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        chk("state", 8'h02, {4'h0, supplyState_q});
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h11, 1'b0);
        digitalPowerGood = 1'b1;
        step(4);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", `DPS_MID_8BIT, readData_q);
        chk("read7", `DPS_MID_7BIT, readData7);
        chk("terminal_connect_register", {4'h0, `DPS_TERMINAL_CONNECT_REGISTER_RESET}, {4'h0, tconOut_q});
        $display("test brown-out done");
    endtask

    task automatic t_analog_late();
        analogPowerGood = 1'b0;
        step(4);
        chk("state", 8'h04, {4'h0, supplyState_q});
        chk("valid", 8'h00, {7'h00, wiperValid_q});
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h33, 1'b1);
        analogPowerGood = 1'b1;
        step(5);
        chk("wiper", 8'h33, wiperCode_q);
        chk("valid", 8'h01, {7'h00, wiperValid_q});
        $display("test analog late done");
    endtask

    task automatic t_sync_reset();
        reset = 1'b1;
        step(2);
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        chk("wiper7", `DPS_MID_7BIT, wiperCode7);
        chk("valid", 8'h00, {7'h00, wiperValid_q});
        chk("terminal_connect_register", {4'h0, `DPS_TERMINAL_CONNECT_REGISTER_RESET}, {4'h0, tconOut_q});
        chk("state", 8'h01, {4'h0, supplyState_q});
        chk("readRst", 8'h00, readData_q);
        docmd(dps_pkg::DPS_OP_WRITE_WIPER, 8'h22, 1'b0);
        reset = 1'b0;
        step(3);
        chk("state", 8'h08, {4'h0, supplyState_q});
        chk("valid", 8'h01, {7'h00, wiperValid_q});
        chk("wiper", `DPS_MID_8BIT, wiperCode_q);
        docmd(dps_pkg::DPS_OP_READ_WIPER, 8'h00, 1'b1);
        chk("read", `DPS_MID_8BIT, readData_q);
        $display("test sync reset done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset            = 1'b1;
        digitalPowerGood = 1'b0;
        analogPowerGood  = 1'b0;
        cmdValid         = 1'b0;
        cmd              = '0;
        err_total        = 0;
        samples_checked  = 0;
        step(8);
        reset = 1'b0;
        step(2);
        t_reset();
        t_analog_first();
        t_digital_up();
        t_commands();
        t_brownout();
        t_analog_late();
        t_sync_reset();
        finish_test();
    end

endmodule
